// [logic/host_queue_command_pointer.sv]
`timescale 1ns/1ps
// Function
// - rx occupancy bytes in bits 12..0
// - receive queue holds 4096 bytes
// - count updates per frame, interrupt if enabled
// - frame dropped when it does not fit the free rx queue space
// - write one queues transmit frame
// - enqueue bit self-clears after transmission
// - write one releases current rx frame
// - release bit self-clears once freed
// - 11-bit tx pointer addresses data writes
// - auto-increment advances pointer by size
// - without auto-increment pointer holds
// - enqueue resets pointer to next frame
// - data reads rx, writes tx queue
// - transmit queue holds 4096 bytes
module host_queue_command_pointer
(
  input  wire logic                SYS_CLK_IN,
  input  wire logic                RESET_IN,
  input  wire logic                HOST_WR_IN,
  input  wire logic                HOST_RD_IN,
  input  wire logic [3:0]          HOST_ADDR_IN,
  input  wire logic [1:0]          HOST_SIZE_IN,
  input  wire logic [31:0]         HOST_WDATA_IN,
  output logic [31:0]              HOST_RDATA_OUT,
  output logic                     HOST_READY_OUT,
  input  wire logic [15:0]         IRQ_ENABLE_IN,
  output logic                     RX_IRQ_OUT,
  input  wire logic                RX_FRAME_DONE_IN,
  input  wire logic [12:0]         RX_FRAME_BYTES_IN,
  output logic                     RX_FRAME_DROP_OUT,
  input  wire logic [31:0]         RX_DATA_IN,
  output logic                     RX_DATA_POP_OUT,
  input  wire logic [12:0]         RX_RELEASE_BYTES_IN,
  output logic                     RX_RELEASE_OUT,
  input  wire logic                RX_RELEASE_DONE_IN,
  output hq_pkg::tx_word_type      TX_WORD_OUT,
  output logic                     TX_WORD_VALID_OUT,
  input  wire logic                TX_WORD_READY_IN,
  output logic                     TX_ENQUEUE_OUT,
  input  wire logic                TX_DONE_IN,
  input  wire logic [10:0]         TX_NEXT_FRAME_IN
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  // offsets are compared in full; unused ones read zero and ignore writes
  wire sel_txcmd = HOST_ADDR_IN == hq_pkg::OFF_TX_ENQUEUE_COMMAND;
  wire sel_rxcmd = HOST_ADDR_IN == hq_pkg::OFF_RX_RELEASE_COMMAND;
  wire sel_ptr   = HOST_ADDR_IN == hq_pkg::OFF_TX_FRAME_POINTER;
  wire sel_data  = HOST_ADDR_IN == hq_pkg::OFF_QUEUE_DATA_LOW;
  wire sel_occ   = HOST_ADDR_IN == hq_pkg::OFF_RX_QUEUE_OCCUPANCY;

  logic                 enqueue_pending;
  logic                 release_pending;
  logic                 auto_increment;
  logic [10:0]          tx_pointer;
  logic [12:0]          rx_bytes_available;
  logic                 frame_accepted;
  hq_pkg::tx_state_type tx_state;
  hq_pkg::tx_state_type next_tx_state;
  logic                 buf_ready;

  // ****************************************************************
  // pointer step per access size
  // ****************************************************************
  // code 3 is no legal size; it steps as a byte so the pointer stays sane
  function automatic logic [10:0] size_step(input logic [1:0] size);
    case (size)
      hq_pkg::SIZE_BYTE:  size_step = 11'h001;
      hq_pkg::SIZE_WORD:  size_step = 11'h002;
      hq_pkg::SIZE_DWORD: size_step = 11'h004;
      default:            size_step = 11'h001;
    endcase
  endfunction

  // ****************************************************************
  // host strobes
  // ****************************************************************
  // a data write stalls while the buffer is full so no word is lost
  wire data_wr     = HOST_WR_IN && sel_data && buf_ready;
  wire data_rd     = HOST_RD_IN && sel_data;
  wire enqueue_wr  = HOST_WR_IN && sel_txcmd
                     && HOST_WDATA_IN[hq_pkg::ENQUEUE_FRAME_BIT];
  wire release_wr  = HOST_WR_IN && sel_rxcmd
                     && HOST_WDATA_IN[hq_pkg::RELEASE_FRAME_BIT];
  // a second command while its bit is set is ignored, not queued
  wire enqueue_go  = enqueue_wr && !enqueue_pending;
  wire release_go  = release_wr && !release_pending;
  wire ptr_wr      = HOST_WR_IN && sel_ptr;

  // a stalled write is refused, not queued: the host holds it until ready
  assign HOST_READY_OUT = !(HOST_WR_IN && sel_data) || buf_ready;

  // ****************************************************************
  // transmit buffer path
  // ****************************************************************
  hq_pkg::tx_word_type tx_word;
  assign tx_word.addr = tx_pointer;
  assign tx_word.data = HOST_WDATA_IN;
  // the size travels with the word so the far side knows its lanes
  assign tx_word.size = HOST_SIZE_IN;

  // the transmit store itself, hq_pkg::TX_QUEUE_BYTES deep, lies past
  // TX_WORD_OUT; this side only names a byte in it and hands the word on
  hq_skid_buffer u_buf
  (
    .clk_in    (SYS_CLK_IN),
    .reset_in  (RESET_IN),
    .data_in   (tx_word),
    .valid_in  (data_wr),
    .ready_out (buf_ready),
    .data_out  (TX_WORD_OUT),
    .valid_out (TX_WORD_VALID_OUT),
    .ready_in  (TX_WORD_READY_IN)
  );

  // ****************************************************************
  // receive occupancy
  // ****************************************************************
  // a done pulse from the release engine only counts while a release is
  // pending, so a stray pulse cannot shrink the occupancy
  hq_rx_counter u_rx
  (
    .clk_in           (SYS_CLK_IN),
    .reset_in         (RESET_IN),
    .frame_done_in    (RX_FRAME_DONE_IN),
    .frame_bytes_in   (RX_FRAME_BYTES_IN),
    .release_in       (release_pending && RX_RELEASE_DONE_IN),
    .release_bytes_in (RX_RELEASE_BYTES_IN),
    .occupancy_out    (rx_bytes_available),
    .accepted_out     (frame_accepted),
    .dropped_out      (RX_FRAME_DROP_OUT)
  );

  // ****************************************************************
  // pointer next value
  // ****************************************************************
  // enqueue wins over a pointer write, so a frame handed to the
  // transmitter is never left with the pointer inside it
  wire [10:0] next_tx_pointer =
      enqueue_go                  ? TX_NEXT_FRAME_IN :
      ptr_wr                      ? HOST_WDATA_IN[10:0] :
      (data_wr && auto_increment) ? tx_pointer + size_step(HOST_SIZE_IN) :
      tx_pointer;

  wire next_auto = ptr_wr
                   ? HOST_WDATA_IN[hq_pkg::AUTO_INCREMENT_BIT]
                   : auto_increment;

  // ****************************************************************
  // transmit sequencing
  // ****************************************************************
  // a command taken in the done cycle goes straight back to busy, or its
  // bit would wait for a done pulse that never comes
  always_comb
  begin
    next_tx_state = tx_state;
    case (tx_state)
      hq_pkg::TX_IDLE: if (enqueue_go) next_tx_state = hq_pkg::TX_BUSY;
      hq_pkg::TX_BUSY: if (TX_DONE_IN) next_tx_state = hq_pkg::TX_DONE;
      hq_pkg::TX_DONE:
        next_tx_state = enqueue_go ? hq_pkg::TX_BUSY : hq_pkg::TX_IDLE;
      default:         next_tx_state = hq_pkg::TX_IDLE;
    endcase
  end

  // ****************************************************************
  // command bits
  // ****************************************************************
  // set wins: a done pulse in the cycle of a fresh command cannot eat it
  wire tx_finished = (tx_state == hq_pkg::TX_BUSY) && TX_DONE_IN;
  wire next_enqueue_pending =
      enqueue_go || (enqueue_pending && !tx_finished);
  wire next_release_pending =
      release_go || (release_pending && !RX_RELEASE_DONE_IN);

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      enqueue_pending <= 1'b0;
    else
      enqueue_pending <= next_enqueue_pending;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      release_pending <= 1'b0;
    else
      release_pending <= next_release_pending;
  end

  // ****************************************************************
  // transmit state and pointer
  // ****************************************************************
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      tx_state <= hq_pkg::TX_IDLE;
    else
      tx_state <= next_tx_state;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      tx_pointer <= hq_pkg::PTR_RESET;
    else
      tx_pointer <= next_tx_pointer;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      auto_increment <= 1'b0;
    else
      auto_increment <= next_auto;
  end

  // ****************************************************************
  // strobes to the queues
  // ****************************************************************
  // one-cycle pulses: the queues act on the edge, the command bits
  // carry the level that the host polls
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      TX_ENQUEUE_OUT <= 1'b0;
    else
      TX_ENQUEUE_OUT <= enqueue_go;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      RX_RELEASE_OUT <= 1'b0;
    else
      RX_RELEASE_OUT <= release_go;
  end

  // ****************************************************************
  // receive interrupt
  // ****************************************************************
  // the enable is registered beside the accept flag, so the pulse comes
  // in the cycle of the occupancy update, gated by the enable as it
  // stood when the frame ended
  logic irq_armed;

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      irq_armed <= 1'b0;
    else
      irq_armed <= IRQ_ENABLE_IN[hq_pkg::RX_IRQ_ENABLE_BIT];
  end

  assign RX_IRQ_OUT = frame_accepted && irq_armed;

  // ****************************************************************
  // read data
  // ****************************************************************
  // reserved bits are tied low in each word, so a host that masks
  // nothing still sees zeros there
  wire [31:0] txcmd_word = {31'h0, enqueue_pending};
  wire [31:0] rxcmd_word = {31'h0, release_pending};
  wire [31:0] ptr_word   = {17'h0, auto_increment, 3'h0, tx_pointer};
  wire [31:0] occ_word   = {19'h0, rx_bytes_available};

  // a data read hands RX_DATA_IN over as it stands and asks for the next
  wire [31:0] read_mux =
      sel_txcmd ? txcmd_word :
      sel_rxcmd ? rxcmd_word :
      sel_ptr   ? ptr_word :
      sel_occ   ? occ_word :
      sel_data  ? RX_DATA_IN :
      32'h0000_0000;

  // read data holds until the next read, so a slow host may take it late
  wire [31:0] next_rdata = HOST_RD_IN ? read_mux : HOST_RDATA_OUT;

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      HOST_RDATA_OUT <= 32'h0000_0000;
    else
      HOST_RDATA_OUT <= next_rdata;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      RX_DATA_POP_OUT <= 1'b0;
    else
      RX_DATA_POP_OUT <= data_rd;
  end

endmodule

// [logic/hq_pkg.sv]
package hq_pkg;

  // ****************************************************************
  // register map (byte offsets on the host bus)
  // ****************************************************************
  localparam logic [3:0] OFF_TX_ENQUEUE_COMMAND = 4'h0;
  localparam logic [3:0] OFF_RX_RELEASE_COMMAND = 4'h2;
  localparam logic [3:0] OFF_TX_FRAME_POINTER   = 4'h4;
  localparam logic [3:0] OFF_QUEUE_DATA_LOW     = 4'h8;
  localparam logic [3:0] OFF_RX_QUEUE_OCCUPANCY = 4'ha;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int ENQUEUE_FRAME_BIT   = 0;
  localparam int RELEASE_FRAME_BIT   = 0;
  localparam int AUTO_INCREMENT_BIT  = 14;
  localparam int PTR_WIDTH           = 11;
  localparam int OCC_WIDTH           = 13;
  localparam int RX_IRQ_ENABLE_BIT   = 13;
  localparam logic [10:0] PTR_RESET  = 11'h000;
  localparam logic [12:0] OCC_RESET  = 13'h0000;

  // ****************************************************************
  // queue sizes
  // ****************************************************************
  localparam logic [12:0] RX_QUEUE_BYTES = 13'h1000;
  localparam logic [12:0] TX_QUEUE_BYTES = 13'h1000;

  // ****************************************************************
  // data access sizes
  // ****************************************************************
  typedef enum logic [1:0]
  {
    SIZE_BYTE  = 2'h0,
    SIZE_WORD  = 2'h1,
    SIZE_DWORD = 2'h2
  } access_size_type;

  typedef struct packed
  {
    logic [10:0] addr;
    logic [31:0] data;
    logic [1:0]  size;
  } tx_word_type;

  typedef enum logic [1:0]
  {
    TX_IDLE = 2'b00,
    TX_BUSY = 2'b01,
    TX_DONE = 2'b11
  } tx_state_type;

endpackage

// [logic/hq_skid_buffer.sv]
`timescale 1ns/1ps
module hq_skid_buffer
(
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  input  wire hq_pkg::tx_word_type data_in,
  input  wire logic                valid_in,
  output logic                     ready_out,
  output hq_pkg::tx_word_type      data_out,
  output logic                     valid_out,
  input  wire logic                ready_in
);

  hq_pkg::tx_word_type slot [2];
  logic                rd_ptr;
  logic                wr_ptr;
  logic [1:0]          count;

  wire push = valid_in && ready_out;
  wire pop  = valid_out && ready_in;

  assign ready_out = (count != 2'h2);
  assign valid_out = (count != 2'h0);
  assign data_out  = slot[rd_ptr];

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        slot[wr_ptr] <= data_in;
        wr_ptr       <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// [logic/hq_rx_counter.sv]
`timescale 1ns/1ps
module hq_rx_counter
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        frame_done_in,
  input  wire logic [12:0] frame_bytes_in,
  input  wire logic        release_in,
  input  wire logic [12:0] release_bytes_in,
  output logic [12:0]      occupancy_out,
  output logic             accepted_out,
  output logic             dropped_out
);

  // a frame that does not fit the free space is dropped whole
  wire [12:0] free_bytes = hq_pkg::RX_QUEUE_BYTES - occupancy_out;
  wire        fits       = frame_bytes_in <= free_bytes;
  wire        accept     = frame_done_in && fits;
  wire [12:0] add_bytes  = accept ? frame_bytes_in : 13'h0000;
  wire [12:0] sub_bytes  = release_in ? release_bytes_in : 13'h0000;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      occupancy_out <= hq_pkg::OCC_RESET;
      accepted_out  <= 1'b0;
      dropped_out   <= 1'b0;
    end
    else
    begin
      occupancy_out <= occupancy_out + add_bytes - sub_bytes;
      accepted_out  <= accept;
      dropped_out   <= frame_done_in && !fits;
    end
  end

endmodule

// [testbench/queue_side_model.sv]
`timescale 1ns/1ps
module queue_side_model
(
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  input  wire logic                slow_in,
  input  wire hq_pkg::tx_word_type word_in,
  input  wire logic                valid_in,
  output logic                     ready_out,
  input  wire logic                enqueue_in,
  output logic                     tx_done_out,
  input  wire logic                release_in,
  output logic                     release_done_out
);
  // ****************************************************************
  // transmit sink and release engine
  // ****************************************************************
  hq_pkg::tx_word_type seen[$];
  int                  tick;
  int                  tx_wait;
  int                  rel_wait;

  // slow mode stalls three cycles in four so the skid buffer fills
  always @(posedge clk_in)
  begin
    tick <= tick + 1;
    if (reset_in)
      {ready_out, tx_done_out, release_done_out} <= 3'h0;
    else
    begin
      if (valid_in && ready_out)
        seen.push_back(word_in);
      ready_out <= !slow_in || (tick % 4 == 0);
      tx_done_out <= (tx_wait == 1);
      release_done_out <= (rel_wait == 1);
    end
    tx_wait <= enqueue_in ? 6 : (tx_wait > 0 ? tx_wait - 1 : 0);
    rel_wait <= release_in ? 3 : (rel_wait > 0 ? rel_wait - 1 : 0);
  end
endmodule

// [testbench/host_queue_checker.sv]
`timescale 1ns/1ps
module host_queue_checker
(
  input wire logic                SYS_CLK_IN,
  input wire logic                RESET_IN,
  input wire logic                HOST_WR_IN,
  input wire logic                HOST_RD_IN,
  input wire logic [3:0]          HOST_ADDR_IN,
  input wire logic [31:0]         HOST_WDATA_IN,
  input wire logic [31:0]         HOST_RDATA_OUT,
  input wire logic                HOST_READY_OUT,
  input wire logic [15:0]         IRQ_ENABLE_IN,
  input wire logic                RX_IRQ_OUT,
  input wire logic                RX_FRAME_DONE_IN,
  input wire logic                RX_FRAME_DROP_OUT,
  input wire logic                RX_DATA_POP_OUT,
  input wire logic                RX_RELEASE_OUT,
  input wire hq_pkg::tx_word_type TX_WORD_OUT,
  input wire logic                TX_WORD_VALID_OUT,
  input wire logic                TX_WORD_READY_IN,
  input wire logic                TX_ENQUEUE_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);

  a_irq_cause:
    assert property (RX_IRQ_OUT |->
      $past(RX_FRAME_DONE_IN & IRQ_ENABLE_IN[13]))
    else $error("irq without enabled frame");
  a_drop_cause:
    assert property (RX_FRAME_DROP_OUT |->
      $past(RX_FRAME_DONE_IN) && !RX_IRQ_OUT)
    else $error("drop without frame");
  a_enqueue_cause:
    assert property (TX_ENQUEUE_OUT |->
      $past(HOST_WR_IN && HOST_ADDR_IN == 4'h0 && HOST_WDATA_IN[0]))
    else $error("enqueue without command");
  a_release_cause:
    assert property (RX_RELEASE_OUT |->
      $past(HOST_WR_IN && HOST_ADDR_IN == 4'h2 && HOST_WDATA_IN[0]))
    else $error("release without command");
  a_pop_cause:
    assert property (RX_DATA_POP_OUT |->
      $past(HOST_RD_IN && HOST_ADDR_IN == 4'h8))
    else $error("pop without data read");
  a_pop_on_read:
    assert property (HOST_RD_IN && HOST_ADDR_IN == 4'h8 |=> RX_DATA_POP_OUT)
    else $error("data read without pop");
  a_word_held:
    assert property (TX_WORD_VALID_OUT && !TX_WORD_READY_IN |=>
      TX_WORD_VALID_OUT && $stable(TX_WORD_OUT))
    else $error("stalled word changed");
  a_stall_only_data:
    assert property (!HOST_READY_OUT |-> HOST_WR_IN && HOST_ADDR_IN == 4'h8)
    else $error("stall outside data write");
  a_occ_reserved:
    assert property (HOST_RD_IN && HOST_ADDR_IN == 4'ha |=>
      HOST_RDATA_OUT[31:13] == 19'h0)
    else $error("occupancy reserved bits set");

  c_stall: cover property (!HOST_READY_OUT);
  c_drop: cover property (RX_FRAME_DROP_OUT);
  c_irq: cover property (RX_IRQ_OUT);
endmodule

bind host_queue_command_pointer host_queue_checker checker_inst
(
  .SYS_CLK_IN, .RESET_IN, .HOST_WR_IN, .HOST_RD_IN, .HOST_ADDR_IN,
  .HOST_WDATA_IN, .HOST_RDATA_OUT, .HOST_READY_OUT, .IRQ_ENABLE_IN,
  .RX_IRQ_OUT, .RX_FRAME_DONE_IN, .RX_FRAME_DROP_OUT, .RX_DATA_POP_OUT,
  .RX_RELEASE_OUT, .TX_WORD_OUT, .TX_WORD_VALID_OUT, .TX_WORD_READY_IN,
  .TX_ENQUEUE_OUT
);

// [testbench/test_host_queue_command_pointer.sv]
`timescale 1ns/1ps
module test_host_queue_command_pointer;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                wr, rd, ready, irq, fdone, drop, pop, rel, reldone;
  logic                txv, txr, enq, txdone, slow;
  logic [3:0]          addr;
  logic [1:0]          size;
  logic [31:0]         wdata, rdata, rxd, v;
  logic [15:0]         irq_en;
  logic [12:0]         fbytes, relb;
  logic [10:0]         nextf;
  logic [3:0]          offs[4] = '{4'h0, 4'h2, 4'h4, 4'ha};
  hq_pkg::tx_word_type txw, g, exp_q[$];
  int                  fail_count, checks_done, occ, ptr, n, seed = 93;

  always #5 clk = ~clk;

  host_queue_command_pointer DUT
  (
    .SYS_CLK_IN(clk), .RESET_IN(rst), .HOST_WR_IN(wr), .HOST_RD_IN(rd),
    .HOST_ADDR_IN(addr), .HOST_SIZE_IN(size), .HOST_WDATA_IN(wdata),
    .HOST_RDATA_OUT(rdata), .HOST_READY_OUT(ready), .IRQ_ENABLE_IN(irq_en),
    .RX_IRQ_OUT(irq), .RX_FRAME_DONE_IN(fdone), .RX_FRAME_BYTES_IN(fbytes),
    .RX_FRAME_DROP_OUT(drop), .RX_DATA_IN(rxd), .RX_DATA_POP_OUT(pop),
    .RX_RELEASE_BYTES_IN(relb), .RX_RELEASE_OUT(rel),
    .RX_RELEASE_DONE_IN(reldone), .TX_WORD_OUT(txw),
    .TX_WORD_VALID_OUT(txv), .TX_WORD_READY_IN(txr), .TX_ENQUEUE_OUT(enq),
    .TX_DONE_IN(txdone), .TX_NEXT_FRAME_IN(nextf)
  );

  queue_side_model partner
  (
    .clk_in(clk), .reset_in(rst), .slow_in(slow), .word_in(txw),
    .valid_in(txv), .ready_out(txr), .enqueue_in(enq),
    .tx_done_out(txdone), .release_in(rel), .release_done_out(reldone)
  );

  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check_val(string what, logic [31:0] e, logic [31:0] got);
    checks_done++;
    if (got !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask

  // a stalled data write keeps its strobe up until the buffer has room
  task automatic host_write(logic [3:0] a, logic [1:0] s, logic [31:0] d);
    logic ok;
    int   k;
    k = 0;
    @(negedge clk);
    {wr, addr, size, wdata} = {1'b1, a, s, d};
    do
    begin
      #1 ok = ready;
      @(negedge clk);
    end
    while (!ok && ++k < 100);
    wr = 1'b0;
  endtask

  task automatic host_read(logic [3:0] a, output logic [31:0] d);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic frame(int b);
    logic fits;
    fits = occ + b <= 4096;
    @(negedge clk);
    {fdone, fbytes} = {1'b1, b[12:0]};
    @(negedge clk);
    fdone = 1'b0;
    check_val("irq", {31'h0, fits & irq_en[13]}, {31'h0, irq});
    check_val("drop", {31'h0, !fits}, {31'h0, drop});
    if (fits)
      occ += b;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    fail_count++;
    test_done();
  end

  initial
  begin
    {wr, rd, fdone, slow, addr, size, wdata, irq_en} = '0;
    {fbytes, relb, nextf, rxd} = '0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    foreach (offs[i])
    begin
      host_read(offs[i], v);
      check_val("reset value", 32'h0, v);
    end
    for (int i = 0; i < 2; i++)
    begin
      host_write(offs[i], 2'h1, 32'hfffe);
      host_read(offs[i], v);
      check_val("command zero write", 32'h0, v);
    end
    $display("test reset done");
    slow = 1'b1;
    ptr = rnd() & 32'h7ff;
    host_write(4'h4, 2'h1, 32'h4000 | ptr);
    for (int i = 0; i < 11; i++)
    begin
      v = rnd();
      exp_q.push_back({i > 8 ? 11'h123 : ptr[10:0], v, 2'(i % 3)});
      if (i == 9)
        host_write(4'h4, 2'h1, 32'h0123);
      host_write(4'h8, 2'(i % 3), v);
      ptr = (ptr + (1 << (i % 3))) & 32'h7ff;
      if (i == 8)
      begin
        host_read(4'h4, v);
        check_val("pointer", 32'h4000 | ptr, v);
      end
    end
    host_read(4'h4, v);
    check_val("pointer held", 32'h123, v);
    n = 0;
    while (partner.seen.size() < exp_q.size() && n++ < 200)
      @(negedge clk);
    check_val("word count", exp_q.size(), partner.seen.size());
    foreach (exp_q[i])
    begin
      g = partner.seen[i];
      check_val("word addr", {21'h0, exp_q[i].addr}, {21'h0, g.addr});
      check_val("word data", exp_q[i].data, g.data);
      check_val("word size", {30'h0, exp_q[i].size}, {30'h0, g.size});
    end
    $display("test pointer done");
    v = rnd();
    nextf = v[10:0];
    host_write(4'h0, 2'h1, 32'h1);
    host_read(4'h0, v);
    check_val("enqueue bit", 32'h1, v);
    host_read(4'h4, v);
    check_val("next frame", {21'h0, nextf}, v & 32'h7ff);
    n = 0;
    do host_read(4'h0, v); while (v[0] && ++n < 20);
    check_val("enqueue cleared", 32'h0, v);
    $display("test enqueue done");
    for (int i = 0; i < 8; i++)
    begin
      irq_en = i[0] ? 16'h2000 : 16'h0;
      v = rnd();
      frame(i == 6 ? 4096 : i == 7 ? 4096 - occ : v[9:0] + 1);
      host_read(4'ha, v);
      check_val("occupancy", occ, v);
    end
    $display("test frames done");
    rxd = rnd();
    host_read(4'h8, v);
    check_val("rx data", rxd, v);
    relb = 13'h40;
    host_write(4'h2, 2'h1, 32'h1);
    host_read(4'h2, v);
    check_val("release bit", 32'h1, v);
    n = 0;
    do host_read(4'h2, v); while (v[0] && ++n < 20);
    occ -= 64;
    host_read(4'ha, v);
    check_val("occupancy released", occ, v);
    $display("test release done");
    test_done();
  end
endmodule
